// ---- core/adc_ctl.sv ----
// Conversion controller: SAR sequencer, channel selects, trigger choice,
// three down counters, sticky events and host request lines, on APB.
// Assumes pins are asynchronous and the comparator is external.
`timescale 1ns/1ps

module adc_ctl #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Asynchronous pins
  input wire logic clk1m_in,
  input wire logic ext_trig_in,
  input wire logic ext_irq_in,
  input wire logic cmp_in,
  input wire logic [2:0] irq_strap,
  // Converter and multiplexer drive
  output logic [11:0] sar_code,
  output logic hold_out,
  output adc_ctl_pkg::mux_sel_t mux_sel,
  output logic [adc_ctl_pkg::NUM_CTR-1:0] ctr_out,
  // Host requests
  output logic irq_out,
  output logic [adc_ctl_pkg::NUM_IRQ-1:0] irq_req
);

  if (ADDR_W != 8) begin : g_chk
    $error("adc_ctl ADDR_W must be 8");
  end

  adc_ctl_pkg::st_t st_r;
  adc_ctl_pkg::st_t st_nxt;

  logic acc;
  logic wr;
  logic setup_rd;
  logic mapped;
  logic ctr_tick;
  logic trig_rise;
  logic eirq_rise;
  logic sw_cmd;
  logic trig_evt;
  logic fin;
  logic irq_active;
  logic [2:0] irq_lvl;
  logic [31:0] rd_val;
  logic [11:0] sar_v;
  logic [adc_ctl_pkg::NUM_EVT-1:0] set_vec;
  logic [adc_ctl_pkg::NUM_EVT-1:0] clr_vec;
  logic [adc_ctl_pkg::NUM_CTR-1:0] ctr_load;
  logic [adc_ctl_pkg::NUM_CTR-1:0] ctr_evt;
  logic [adc_ctl_pkg::CTR_W-1:0] ctr_cnt [adc_ctl_pkg::NUM_CTR];

  // Bus phases; every access completes without wait states
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign setup_rd = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;

  // Edges only from second synchroniser stages and their delayed copies
  assign ctr_tick = !st_r.clk_s[1] && st_r.clk_d;
  assign trig_rise = st_r.trig_s[1] && !st_r.trig_d;
  assign eirq_rise = st_r.eirq_s[1] && !st_r.eirq_d;
  assign sw_cmd = wr && paddr == adc_ctl_pkg::OFF_CMD &&
                  pwdata[adc_ctl_pkg::CMD_START_BIT];
  assign irq_lvl = st_r.strap_s[5:3];

  // Counters, each reloaded by a write to its own word
  for (genvar i = 0; i < adc_ctl_pkg::NUM_CTR; i++) begin : g_ctr
    localparam logic [7:0] OFF_I = 8'(adc_ctl_pkg::OFF_CNT0 + 4 * i);
    assign ctr_load[i] = wr && paddr == OFF_I;
    down_counter #(
      .WIDTH(adc_ctl_pkg::CTR_W)
    ) u_ctr (
      .pclk(pclk),
      .presetn(presetn),
      .tick(ctr_tick),
      .load(ctr_load[i]),
      .load_val(pwdata[adc_ctl_pkg::CTR_W-1:0]),
      .count(ctr_cnt[i]),
      .event_out(ctr_evt[i])
    );
  end

  // Trigger choice; a counter index past the last one never fires
  always_comb begin
    trig_evt = 1'b0;
    case (st_r.ctrl.trig)
      adc_ctl_pkg::TRIG_EXT: trig_evt = trig_rise;
      adc_ctl_pkg::TRIG_CTR: begin
        if (st_r.ctrl.csel < 2'(adc_ctl_pkg::NUM_CTR)) begin
          trig_evt = ctr_evt[st_r.ctrl.csel];
        end
      end
      adc_ctl_pkg::TRIG_SW: trig_evt = sw_cmd;
      default: trig_evt = 1'b0;
    endcase
  end

  // Read mux and address map
  always_comb begin
    rd_val = 32'h0000_0000;
    mapped = 1'b1;
    case (paddr)
      adc_ctl_pkg::OFF_CTRL: rd_val = 32'(st_r.ctrl);
      adc_ctl_pkg::OFF_CMD: rd_val = 32'h0000_0000;
      adc_ctl_pkg::OFF_STATUS: begin
        rd_val = 32'(st_r.status);
        rd_val[adc_ctl_pkg::ST_BUSY] = st_r.conv != adc_ctl_pkg::CONV_IDLE;
      end
      adc_ctl_pkg::OFF_MASK: rd_val = 32'(st_r.mask);
      adc_ctl_pkg::OFF_RESULT: rd_val = 32'(st_r.result);
      adc_ctl_pkg::OFF_IRQLVL: rd_val = 32'(irq_lvl);
      default: begin
        mapped = 1'b0;
        for (int k = 0; k < adc_ctl_pkg::NUM_CTR; k++) begin
          if (paddr == 8'(adc_ctl_pkg::OFF_CNT0 + 4 * k)) begin
            mapped = 1'b1;
            rd_val = 32'(ctr_cnt[k]);
          end
        end
      end
    endcase
  end

  // Next-state logic for the whole block
  always_comb begin
    st_nxt = st_r;
    fin = 1'b0;
    sar_v = st_r.sar;
    set_vec = '0;
    clr_vec = '0;
    // Synchronisers: first stage feeds only the second
    st_nxt.clk_s = {st_r.clk_s[0], clk1m_in};
    st_nxt.clk_d = st_r.clk_s[1];
    st_nxt.trig_s = {st_r.trig_s[0], ext_trig_in};
    st_nxt.trig_d = st_r.trig_s[1];
    st_nxt.eirq_s = {st_r.eirq_s[0], ext_irq_in};
    st_nxt.eirq_d = st_r.eirq_s[1];
    st_nxt.cmp_s = {st_r.cmp_s[0], cmp_in};
    st_nxt.strap_s = {st_r.strap_s[2:0], irq_strap};
    // Read data is latched in the setup phase so prdata is a flop
    if (setup_rd) begin
      st_nxt.prdata = rd_val;
    end
    // Register writes
    if (wr) begin
      case (paddr)
        adc_ctl_pkg::OFF_CTRL: begin
          st_nxt.ctrl.chan = pwdata[adc_ctl_pkg::CTRL_CHAN_LSB +: 3];
          st_nxt.ctrl.exp = pwdata[adc_ctl_pkg::CTRL_EXP_LSB +: 4];
          st_nxt.ctrl.trig = pwdata[adc_ctl_pkg::CTRL_TRIG_LSB +: 2];
          st_nxt.ctrl.gate = pwdata[adc_ctl_pkg::CTRL_GATE_BIT];
          st_nxt.ctrl.csel = pwdata[adc_ctl_pkg::CTRL_CSEL_LSB +: 2];
          clr_vec = '1;
        end
        adc_ctl_pkg::OFF_STATUS: begin
          clr_vec = pwdata[adc_ctl_pkg::NUM_EVT-1:0];
        end
        adc_ctl_pkg::OFF_MASK: begin
          st_nxt.mask = pwdata[adc_ctl_pkg::NUM_EVT-1:0];
        end
        default: st_nxt.mask = st_r.mask;
      endcase
    end
    // SAR sequencer; triggers while busy are ignored
    case (st_r.conv)
      adc_ctl_pkg::CONV_IDLE: begin
        if (trig_evt) begin
          st_nxt.conv = adc_ctl_pkg::CONV_HOLD;
          st_nxt.timer = adc_ctl_pkg::HOLD_CYC - 16'h0001;
        end
      end
      adc_ctl_pkg::CONV_HOLD: begin
        if (st_r.timer == 16'h0000) begin
          st_nxt.conv = adc_ctl_pkg::CONV_TRIAL;
          st_nxt.bitidx = adc_ctl_pkg::MSB_IDX;
          st_nxt.sar = adc_ctl_pkg::SAR_MSB;
          st_nxt.timer = adc_ctl_pkg::BIT_CYC - 16'h0001;
        end else begin
          st_nxt.timer = st_r.timer - 16'h0001;
        end
      end
      adc_ctl_pkg::CONV_TRIAL: begin
        if (st_r.timer == 16'h0000) begin
          // Comparator low means the trial code overshot the input
          if (!st_r.cmp_s[1]) begin
            sar_v[st_r.bitidx] = 1'b0;
          end
          if (st_r.bitidx == 4'h0) begin
            fin = 1'b1;
            st_nxt.result = sar_v;
            st_nxt.conv = adc_ctl_pkg::CONV_IDLE;
          end else begin
            sar_v[st_r.bitidx - 4'h1] = 1'b1;
            st_nxt.bitidx = st_r.bitidx - 4'h1;
            st_nxt.timer = adc_ctl_pkg::BIT_CYC - 16'h0001;
          end
          st_nxt.sar = sar_v;
        end else begin
          st_nxt.timer = st_r.timer - 16'h0001;
        end
      end
      default: st_nxt.conv = adc_ctl_pkg::CONV_IDLE;
    endcase
    // Sticky events; a set in the clearing cycle survives
    set_vec[adc_ctl_pkg::ST_EOC] = fin;
    set_vec[adc_ctl_pkg::ST_EXT] = eirq_rise;
    set_vec[adc_ctl_pkg::ST_CTR0 +: adc_ctl_pkg::NUM_CTR] = ctr_evt;
    st_nxt.status = (st_r.status & ~clr_vec) | set_vec;
  end

  // State register; reset drops every pending event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
      st_r.ctrl <= adc_ctl_pkg::CTRL_RST;
      st_r.conv <= adc_ctl_pkg::CONV_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Request gating and one-hot line choice from the strap
  assign irq_active = st_r.ctrl.gate && |(st_r.status & st_r.mask);
  assign irq_out = irq_active;
  always_comb begin
    irq_req = '0;
    for (int j = 0; j < adc_ctl_pkg::NUM_IRQ; j++) begin
      if (irq_lvl == 3'(j) + adc_ctl_pkg::IRQ_LVL_MIN) begin
        irq_req[j] = irq_active;
      end
    end
  end

  // Drive outputs; the eight-channel select reuses the low bits
  assign prdata = st_r.prdata;
  assign sar_code = st_r.sar;
  assign hold_out = st_r.conv != adc_ctl_pkg::CONV_IDLE;
  assign mux_sel.onboard = st_r.ctrl.chan;
  assign mux_sel.exp16 = st_r.ctrl.exp;
  assign mux_sel.exp8 = st_r.ctrl.exp[2:0];
  assign ctr_out = ctr_evt;

  // Busy-time counter read only by the conversion bound check
  logic [15:0] conv_age;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_age <= 16'h0000;
    end else if (st_r.conv == adc_ctl_pkg::CONV_IDLE) begin
      conv_age <= 16'h0000;
    end else begin
      conv_age <= conv_age + 16'h0001;
    end
  end

  sequence s_start;
    st_r.conv == adc_ctl_pkg::CONV_IDLE && trig_evt;
  endsequence

  sequence s_held;
    hold_out && st_r.conv == adc_ctl_pkg::CONV_HOLD;
  endsequence

  a_conv_bound: assert property (@(posedge pclk) disable iff (!presetn)
    conv_age < 16'(adc_ctl_pkg::CONV_MAX_CYC))
    else $error("conversion exceeded its longest time");

  a_sw_start: assert property (@(posedge pclk) disable iff (!presetn)
    (s_start and (st_r.ctrl.trig == adc_ctl_pkg::TRIG_SW)) |=> s_held)
    else $error("software command did not start conversion");

  a_ctr_start: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.conv == adc_ctl_pkg::CONV_IDLE &&
     st_r.ctrl.trig == adc_ctl_pkg::TRIG_CTR && st_r.ctrl.csel == 2'h0 &&
     ctr_evt[0]) |=> s_held)
    else $error("counter event did not start conversion");

  a_chan_select: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == adc_ctl_pkg::OFF_CTRL) |=>
      (mux_sel.onboard == $past(pwdata[2:0]) &&
       mux_sel.exp16 == $past(pwdata[6:3])))
    else $error("channel selects did not follow command write");

  a_exp8_tie: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == adc_ctl_pkg::OFF_CTRL) |=>
      (mux_sel.exp8 == $past(pwdata[5:3])))
    else $error("eight-channel select wrong");

  a_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (irq_req != '0) |-> (st_r.ctrl.gate && irq_out))
    else $error("request raised with gate closed");

  a_irq_onehot: assert property (@(posedge pclk) disable iff (!presetn)
    irq_out && irq_lvl >= adc_ctl_pkg::IRQ_LVL_MIN |->
      $onehot(irq_req))
    else $error("request not on exactly one line");

  a_ext_edge: assert property (@(posedge pclk) disable iff (!presetn)
    (eirq_rise && !(wr && paddr == adc_ctl_pkg::OFF_CTRL)) |=>
      st_r.status[adc_ctl_pkg::ST_EXT])
    else $error("external rising edge not recorded");

  a_cmd_ack: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == adc_ctl_pkg::OFF_CTRL && set_vec == '0) |=>
      (st_r.status == '0 && !irq_out))
    else $error("command write did not clear request");

  a_eoc_event: assert property (@(posedge pclk) disable iff (!presetn)
    fin |=> (st_r.status[adc_ctl_pkg::ST_EOC] &&
             st_r.result == $past(sar_v)))
    else $error("end of conversion not recorded");

  a_result_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !fin |=> $stable(st_r.result))
    else $error("result changed without a finished conversion");

endmodule // adc_ctl

// ---- common/adc_ctl_pkg.sv ----
// Shared constants, field layouts and types for the conversion controller.
// Assumes one 100 MHz APB clock and a byte-addressed 8-bit APB window.
package adc_ctl_pkg;

  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned CONV_TYP_NS = 25000;
  localparam int unsigned CONV_MAX_NS = 35000;
  localparam int unsigned HOLD_NS = 1000;
  localparam int unsigned BIT_NS = 2000;
  // Least times round up
  localparam logic [15:0] HOLD_CYC =
    16'((HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] BIT_CYC =
    16'((BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // Longest time rounds down
  localparam int unsigned CONV_MAX_CYC = CONV_MAX_NS / CLK_PERIOD_NS;

  // Converter geometry
  localparam int unsigned RES_BITS = 12;
  localparam logic [3:0] MSB_IDX = 4'hb;
  localparam logic [11:0] SAR_MSB = 12'h800;
  localparam int unsigned NUM_CTR = 3;
  localparam int unsigned CTR_W = 16;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CMD = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_MASK = 8'h0c;
  localparam logic [7:0] OFF_RESULT = 8'h10;
  localparam logic [7:0] OFF_CNT0 = 8'h14;
  localparam logic [7:0] OFF_IRQLVL = 8'h20;

  // Control word field positions
  localparam int unsigned CTRL_CHAN_LSB = 0;
  localparam int unsigned CTRL_EXP_LSB = 3;
  localparam int unsigned CTRL_TRIG_LSB = 7;
  localparam int unsigned CTRL_GATE_BIT = 9;
  localparam int unsigned CTRL_CSEL_LSB = 10;
  localparam int unsigned CMD_START_BIT = 0;

  // Status bit positions (event bits are sticky, write one to clear)
  localparam int unsigned ST_EOC = 0;
  localparam int unsigned ST_EXT = 1;
  localparam int unsigned ST_CTR0 = 2;
  localparam int unsigned NUM_EVT = 5;
  localparam int unsigned ST_BUSY = 8;

  // Trigger source encodings
  localparam logic [1:0] TRIG_EXT = 2'h0;
  localparam logic [1:0] TRIG_CTR = 2'h1;
  localparam logic [1:0] TRIG_SW = 2'h2;

  // Lowest host request line served by the strap
  localparam logic [2:0] IRQ_LVL_MIN = 3'h2;
  localparam int unsigned NUM_IRQ = 6;

  typedef enum logic [1:0] {
    CONV_IDLE,
    CONV_HOLD,
    CONV_TRIAL
  } conv_state_t;

  typedef struct packed {
    logic [1:0] csel;
    logic gate;
    logic [1:0] trig;
    logic [3:0] exp;
    logic [2:0] chan;
  } ctrl_t;

  localparam ctrl_t CTRL_RST = '{csel: 2'h0, gate: 1'b0, trig: TRIG_SW,
                                 exp: 4'h0, chan: 3'h0};

  // Multiplexer selects that travel together
  typedef struct packed {
    logic [2:0] onboard;
    logic [3:0] exp16;
    logic [2:0] exp8;
  } mux_sel_t;

  typedef struct packed {
    logic [1:0] clk_s;
    logic clk_d;
    logic [1:0] trig_s;
    logic trig_d;
    logic [1:0] eirq_s;
    logic eirq_d;
    logic [1:0] cmp_s;
    logic [5:0] strap_s;
    ctrl_t ctrl;
    logic [NUM_EVT-1:0] status;
    logic [NUM_EVT-1:0] mask;
    conv_state_t conv;
    logic [15:0] timer;
    logic [3:0] bitidx;
    logic [11:0] sar;
    logic [11:0] result;
    logic [31:0] prdata;
  } st_t;

endpackage

// ---- core/down_counter.sv ----
// One reloading down counter, stepped by a one-cycle tick.
// Assumes the tick comes from a synchronised falling clock edge on pclk.
`timescale 1ns/1ps
module down_counter #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Count control
  input wire logic tick,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_val,
  // Results
  output logic [WIDTH-1:0] count,
  output logic event_out
);

  if (WIDTH < 2) begin : g_chk
    $error("down_counter WIDTH must be at least 2");
  end

  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] reload;
    logic evt;
  } cnt_st_t;

  cnt_st_t st_r;
  cnt_st_t st_nxt;

  // Load wins over a tick; zero reload leaves the counter parked
  always_comb begin
    st_nxt = st_r;
    st_nxt.evt = 1'b0;
    if (load) begin
      st_nxt.count = load_val;
      st_nxt.reload = load_val;
    end else if (tick && st_r.count != '0) begin
      if (st_r.count == WIDTH'(1)) begin
        st_nxt.count = st_r.reload;
        st_nxt.evt = 1'b1;
      end else begin
        st_nxt.count = st_r.count - WIDTH'(1);
      end
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign count = st_r.count;
  assign event_out = st_r.evt;

  a_count_step: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && !load && st_r.count > WIDTH'(1)) |=>
      (count == WIDTH'($past(count) - WIDTH'(1))))
    else $error("counter did not step down on tick");

  a_reload_evt: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && !load && st_r.count == WIDTH'(1)) |=>
      (event_out && count == $past(st_r.reload)))
    else $error("counter did not reload with event");

endmodule // down_counter

// ---- bench/far_side_model.sv ----
// Far-side model: on-board multiplexer levels and the SAR comparator.
// Assumes the block drives sar_code, hold_out and mux_sel from pclk flops.
`timescale 1ns/1ps
module far_side_model (
  // Converter drive from the block
  input wire logic pclk,
  input wire logic hold_out,
  input wire logic [11:0] sar_code,
  input wire adc_ctl_pkg::mux_sel_t mux_sel,
  // Comparator answer
  output logic cmp_in
);
  logic [11:0] level;
  logic flip;
  initial flip = 1'b0;
  // Each on-board channel carries its own fixed level
  assign level = {mux_sel.onboard, 9'h0a3};
  // Toggling when idle, so a stray sample outside a conversion shows up
  always @(posedge pclk) flip <= ~flip;
  // Comparator only meaningful while the sample is held
  assign cmp_in = hold_out ? (level >= sar_code) : flip;
endmodule // far_side_model

// ---- bench/test_adc_ctl.sv ----
// Self-checking bench for the conversion controller over APB.
// Assumes adc_ctl_pkg and far_side_model are compiled first.
`timescale 1ns/1ps
module test_adc_ctl;
  // Bus and pins
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic clk1m_in, ext_trig_in, ext_irq_in, cmp_in, hold_out, irq_out;
  logic [2:0] irq_strap;
  logic [11:0] sar_code;
  adc_ctl_pkg::mux_sel_t mux_sel;
  logic [adc_ctl_pkg::NUM_CTR-1:0] ctr_out;
  logic [adc_ctl_pkg::NUM_IRQ-1:0] irq_req;
  int n_errors, checks_done;
  time t0;
  // Sticky record of counter event pulses, which stand one cycle only
  logic [adc_ctl_pkg::NUM_CTR-1:0] ctr_seen = '0;
  always @(posedge pclk) ctr_seen <= ctr_seen | ctr_out;

  adc_ctl #(.ADDR_W(8)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clk1m_in(clk1m_in), .ext_trig_in(ext_trig_in), .ext_irq_in(ext_irq_in),
    .cmp_in(cmp_in), .irq_strap(irq_strap), .sar_code(sar_code),
    .hold_out(hold_out), .mux_sel(mux_sel), .ctr_out(ctr_out),
    .irq_out(irq_out), .irq_req(irq_req));

  far_side_model i_far (.pclk(pclk), .hold_out(hold_out),
    .sar_code(sar_code), .mux_sel(mux_sel), .cmp_in(cmp_in));

  // Free-running bus clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One APB transfer; result lands in rd and err at the pready edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp,
                     input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk(rd & m, exp);
  endtask

  // Control word in the block's field layout
  function automatic logic [31:0] ctl(input logic [2:0] ch,
    input logic [3:0] ex, input logic [1:0] tr, input logic g,
    input logic [1:0] cs);
    return {20'h0, cs, g, tr, ex, ch};
  endfunction

  // Pin selectors for the slow-edge task
  localparam int P_CLK = 0;
  localparam int P_TRIG = 1;
  localparam int P_IRQ = 2;

  // Slow pin edge, long enough for the two-flop synchronisers
  task automatic pin(input int sel, input logic v);
    @(posedge pclk);
    case (sel)
      P_CLK: clk1m_in <= v;
      P_TRIG: ext_trig_in <= v;
      default: ext_irq_in <= v;
    endcase
    repeat (60) @(posedge pclk);
  endtask

  // Poll for end of conversion, then bound the elapsed time
  task automatic wait_eoc();
    int i;
    i = 0;
    rd = 32'h0;
    while (rd[0] !== 1'b1 && i < 1500) begin
      apb(1'b0, adc_ctl_pkg::OFF_STATUS, 32'h0);
      i++;
    end
    chk(32'(rd[0]), 32'h1);
    chk(32'(($time - t0) < adc_ctl_pkg::CONV_MAX_NS), 32'h1);
    chk(32'(hold_out), 32'h0);
  endtask

  // Hang guard, far beyond three conversions
  initial begin
    repeat (40000) @(posedge pclk);
    n_errors++;
    $display("watchdog expired");
    end_sim();
  end

  // Main sequence
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    clk1m_in = 1'b1;
    ext_trig_in = 1'b0;
    ext_irq_in = 1'b0;
    irq_strap = 3'h3;
    presetn = 1'b0;
    n_errors = 0;
    checks_done = 0;
    t0 = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    rdc(adc_ctl_pkg::OFF_CTRL, 32'h00000100, '1);
    rdc(adc_ctl_pkg::OFF_RESULT, 32'h0, '1);
    rdc(adc_ctl_pkg::OFF_IRQLVL, 32'h3, '1);
    rdc(8'h24, 32'h0, '1);
    chk(32'(err), 32'h1);
    $display("test reset_and_map done");

    // Selects follow the written channel fields
    wr(adc_ctl_pkg::OFF_CTRL, ctl(3'h5, 4'hb, adc_ctl_pkg::TRIG_SW, 0, 3));
    @(posedge pclk);
    chk(32'(mux_sel.onboard), 32'h5);
    chk(32'(mux_sel.exp16), 32'hb);
    chk(32'(mux_sel.exp8), 32'h3);
    $display("test channel_select done");

    // Software start, end-of-conversion request, acknowledge by CTRL
    wr(adc_ctl_pkg::OFF_MASK, 32'h1);
    wr(adc_ctl_pkg::OFF_CTRL, ctl(3'h5, 4'hb, adc_ctl_pkg::TRIG_SW, 1, 3));
    t0 = $time;
    wr(adc_ctl_pkg::OFF_CMD, 32'h1);
    repeat (3) @(posedge pclk);
    chk(32'(hold_out), 32'h1);
    wait_eoc();
    rdc(adc_ctl_pkg::OFF_RESULT, {20'h0, 3'h5, 9'h0a3}, '1);
    chk(32'(sar_code), {20'h0, 3'h5, 9'h0a3});
    chk(32'(irq_out), 32'h1);
    chk(32'(irq_req), 32'h2);
    wr(adc_ctl_pkg::OFF_CTRL, ctl(3'h2, 4'hb, adc_ctl_pkg::TRIG_SW, 1, 3));
    @(posedge pclk);
    chk(32'(irq_out), 32'h0);
    chk(32'(irq_req), 32'h0);
    rdc(adc_ctl_pkg::OFF_RESULT, {20'h0, 3'h5, 9'h0a3}, '1);
    $display("test sw_conversion done");

    // External edge: gated off, level ignored, W1C, host reset
    wr(adc_ctl_pkg::OFF_MASK, 32'h2);
    wr(adc_ctl_pkg::OFF_CTRL, ctl(3'h2, 4'h0, adc_ctl_pkg::TRIG_SW, 0, 3));
    pin(P_IRQ, 1'b1);
    rdc(adc_ctl_pkg::OFF_STATUS, 32'h2, 32'h2);
    chk(32'(irq_out), 32'h0);
    wr(adc_ctl_pkg::OFF_CTRL, ctl(3'h2, 4'h0, adc_ctl_pkg::TRIG_SW, 1, 3));
    repeat (20) @(posedge pclk);
    rdc(adc_ctl_pkg::OFF_STATUS, 32'h0, 32'h2);
    pin(P_IRQ, 1'b0);
    pin(P_IRQ, 1'b1);
    chk(32'(irq_out), 32'h1);
    wr(adc_ctl_pkg::OFF_STATUS, 32'h2);
    @(posedge pclk);
    chk(32'(irq_out), 32'h0);
    pin(P_IRQ, 1'b0);
    pin(P_IRQ, 1'b1);
    chk(32'(irq_out), 32'h1);
    // Pin drops while reset holds, so release sees no real edge
    @(posedge pclk);
    presetn <= 1'b0;
    ext_irq_in <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(32'(irq_out), 32'h0);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    rdc(adc_ctl_pkg::OFF_STATUS, 32'h0, 32'h1f);
    pin(P_IRQ, 1'b0);
    $display("test ext_interrupt done");

    // Counter: full width, falling-edge step, periodic trigger and irq
    wr(adc_ctl_pkg::OFF_MASK, 32'h4);
    wr(adc_ctl_pkg::OFF_CTRL, ctl(3'h0, 4'h0, adc_ctl_pkg::TRIG_CTR, 1, 0));
    wr(adc_ctl_pkg::OFF_CNT0, 32'hffff);
    rdc(adc_ctl_pkg::OFF_CNT0, 32'hffff, 32'hffff);
    wr(adc_ctl_pkg::OFF_CNT0, 32'h3);
    pin(P_CLK, 1'b0);
    rdc(adc_ctl_pkg::OFF_CNT0, 32'h2, 32'hffff);
    pin(P_CLK, 1'b1);
    rdc(adc_ctl_pkg::OFF_CNT0, 32'h2, 32'hffff);
    chk(32'(ctr_seen), 32'h0);
    pin(P_CLK, 1'b0);
    pin(P_CLK, 1'b1);
    t0 = $time;
    pin(P_CLK, 1'b0);
    rdc(adc_ctl_pkg::OFF_STATUS, 32'h104, 32'h104);
    chk(32'(irq_out), 32'h1);
    chk(32'(ctr_seen), 32'h1);
    wait_eoc();
    rdc(adc_ctl_pkg::OFF_RESULT, {20'h0, 3'h0, 9'h0a3}, '1);
    wr(adc_ctl_pkg::OFF_CNT0, 32'h0);
    $display("test counter_trigger done");

    // External trigger source
    wr(adc_ctl_pkg::OFF_CTRL, ctl(3'h7, 4'h0, adc_ctl_pkg::TRIG_EXT, 0, 3));
    t0 = $time;
    pin(P_TRIG, 1'b1);
    wait_eoc();
    rdc(adc_ctl_pkg::OFF_RESULT, {20'h0, 3'h7, 9'h0a3}, '1);
    pin(P_TRIG, 1'b0);
    $display("test ext_trigger done");
    end_sim();
  end
endmodule // test_adc_ctl
